// ==== common/mbm_map.vh ====
`ifndef MBM_MAP_VH
`define MBM_MAP_VH
// ----------------------------------------------------------------
// widths of the long word, the port word and the port byte
// ----------------------------------------------------------------
`define MBM_LONG_W     36
`define MBM_WORD_W     18
`define MBM_BYTE_W     9
// ----------------------------------------------------------------
// field positions on port a and in the long word
// ----------------------------------------------------------------
`define MBM_CA_MAIL_LSB 18
`define MBM_WORD_MSB   17
`define MBM_BYTE_MSB   8
// ----------------------------------------------------------------
// data fifo shape
// ----------------------------------------------------------------
`define MBM_FIFO_DEPTH 8
`define MBM_FIFO_AW    3
// ----------------------------------------------------------------
// last part index of a long word per port size
// ----------------------------------------------------------------
`define MBM_LAST_WORD  2'h1
`define MBM_LAST_BYTE  2'h3
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MBM_FLAG_RST   1'b1
`define MBM_BIG_RST    1'b1
`define MBM_BYTE_RST   1'b0
`define MBM_PREV_RST   1'b0
`endif

// ==== rtl/mbm_fifo.v ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// synchronous data fifo with valid and ready on both sides
// ----------------------------------------------------------------
module mbm_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             clear,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  // honest full and empty from the word count
  assign in_ready  = (count != DEPTH[AW:0]) && !clear;
  assign out_valid = (count != {(AW+1){1'b0}}) && !clear;
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage array, written only on an accepted push
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and count; clear drops every stored word
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else if (clear) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // mbm_fifo
`default_nettype wire

// ==== rtl/mbm_pack.v ====
`timescale 1ns/1ps
`default_nettype none
`include "mbm_map.vh"
// ----------------------------------------------------------------
// port c assembler: gathers bytes or words into one long word
// ----------------------------------------------------------------
module mbm_pack (
  input  wire                   clk,
  input  wire                   rst,
  input  wire                   clear,
  input  wire                   byte_mode,
  input  wire                   big,
  input  wire                   wr_valid,
  input  wire                   wr_ready,
  input  wire [`MBM_WORD_W-1:0] wr_data,
  output wire                   word_valid,
  output wire [`MBM_LONG_W-1:0] word_data
);
  reg [`MBM_LONG_W-1:0] aux;
  reg [`MBM_LONG_W-1:0] next_aux;
  reg [1:0]             part;
  reg [1:0]             lane;
  wire [1:0]            last;
  wire                  take;

  assign last       = byte_mode ? `MBM_LAST_BYTE : `MBM_LAST_WORD;
  assign take       = wr_valid && wr_ready;
  // the edge of the last part pushes the whole long word
  assign word_valid = take && (part == last);
  assign word_data  = next_aux;

  // place this part in its lane by endian order
  always @* begin
    next_aux = aux;
    lane     = 2'h0;
    if (byte_mode) begin
      lane = big ? (`MBM_LAST_BYTE - part) : part;
      // only c8..c0 carry a byte
      next_aux[lane*`MBM_BYTE_W +: `MBM_BYTE_W] =
        wr_data[`MBM_BYTE_MSB:0];
    end else begin
      lane = big ? (`MBM_LAST_WORD - part) : part;
      next_aux[lane[0]*`MBM_WORD_W +: `MBM_WORD_W] = wr_data;
    end
  end

  // earlier parts wait in the auxiliary register
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      aux  <= {`MBM_LONG_W{1'b0}};
      part <= 2'h0;
    end else if (clear) begin
      aux  <= {`MBM_LONG_W{1'b0}};
      part <= 2'h0;
    end else if (take) begin
      aux  <= next_aux;
      part <= (part == last) ? 2'h0 : part + 2'h1;
    end
  end
endmodule // mbm_pack
`default_nettype wire

// ==== rtl/mbm_top.v ====
`timescale 1ns/1ps
`default_nettype none
`include "mbm_map.vh"
// ----------------------------------------------------------------
// mailbox and bus matching ports of a triple port fifo
// ----------------------------------------------------------------
// Contract
// - one 18-bit mail register each way, a to b and c to a.
// - mail select per port picks mail register or fifo.
// - port a write with mail select high loads a-to-b mail.
// - a-to-b mail takes a17..a0 (word) or a8..a0 (byte).
// - port c mail write takes c17..c0 or c8..c0 by size.
// - mail write drives full flag low; writes ignored while low.
// - enabled outputs show fifo register or mail by mail select.
// - port b mail read sets a-to-b flag high; data on b lanes.
// - port a mail read sets c-to-a flag high; data on a35..a18.
// - reading mail never changes it; only accepted writes do.
// - endian setting never reorders mail data.
// - b and c sized word or byte, applied at master reset end.
// - big endian sends most significant first, little least first.
// - endian sampled on master reset rise, shared by b and c.
// - fifos hold only 36-bit long words; conversion at the edges.
// - narrow b reads show first part, hold rest, then send it.
// - byte reads leave b17..b9 without defined data.
// - c parts wait in aux; last part pushes the long word.
// - byte writes ignore c17..c9.
module mbm_top (
  input  wire                   clk,
  input  wire                   rst,
  input  wire                   fifo1_master_reset_n,
  input  wire                   fifo2_master_reset_n,
  input  wire                   fifo1_partial_reset_n,
  input  wire                   fifo2_partial_reset_n,
  input  wire                   big_endian_sel,
  input  wire                   portb_byte_size_sel,
  input  wire                   portc_byte_size_sel,
  input  wire                   porta_chip_select_n,
  input  wire                   porta_write_not_read,
  input  wire                   porta_enable,
  input  wire                   porta_mail_select,
  input  wire [`MBM_LONG_W-1:0] porta_data_in,
  output wire [`MBM_LONG_W-1:0] porta_data_out,
  output wire                   porta_data_oe,
  input  wire                   portb_chip_select_n,
  input  wire                   portb_read_enable,
  input  wire                   portb_mail_select,
  output wire [`MBM_WORD_W-1:0] portb_data_out,
  output wire                   portb_data_oe,
  input  wire                   portc_write_enable,
  input  wire                   portc_mail_select,
  input  wire [`MBM_WORD_W-1:0] portc_data_in,
  output wire                   fifo1_full_or_input_ready,
  output wire                   fifo2_full_or_input_ready,
  output wire                   fifo1_output_ready,
  output wire                   fifo2_output_ready,
  output reg                    a_to_b_mail_full_n,
  output reg                    c_to_a_mail_full_n
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [`MBM_WORD_W-1:0] a_to_b_mail_reg;
  reg  [`MBM_WORD_W-1:0] c_to_a_mail_reg;
  reg  [`MBM_LONG_W-1:0] porta_out_reg;
  reg  [`MBM_WORD_W-1:0] portb_out_reg;
  reg  [`MBM_LONG_W-1:0] hold;
  reg  [1:0]             part;
  reg                    cfg_big;
  reg                    cfg_b_byte;
  reg                    cfg_c_byte;
  reg                    mst1_prev;
  reg                    mst2_prev;
  wire                   f1_clear;
  wire                   f2_clear;
  wire                   a_wr;
  wire                   a_rd;
  wire                   b_rd;
  wire                   c_wr;
  wire                   f1_in_ready;
  wire                   f1_out_valid;
  wire                   f1_pop;
  wire [`MBM_LONG_W-1:0] f1_out_data;
  wire                   f2_in_ready;
  wire                   f2_in_valid;
  wire [`MBM_LONG_W-1:0] f2_in_data;
  wire                   f2_out_valid;
  wire                   f2_pop;
  wire [`MBM_LONG_W-1:0] f2_out_data;
  wire [1:0]             b_last;

  // ----------------------------------------------------------------
  // part select for port b reads
  // ----------------------------------------------------------------
  function [`MBM_WORD_W-1:0] part_sel;
    input [`MBM_LONG_W-1:0] lw;
    input [1:0]             k;
    input                   byte_m;
    input                   big;
    reg   [1:0]             j;
    begin
      if (byte_m) begin
        j = big ? (`MBM_LAST_BYTE - k) : k;
        // b17..b9 carry nothing defined, driven low
        part_sel = {{(`MBM_WORD_W-`MBM_BYTE_W){1'b0}},
                    lw[j*`MBM_BYTE_W +: `MBM_BYTE_W]};
      end else begin
        j = big ? (`MBM_LAST_WORD - k) : k;
        part_sel = lw[j[0]*`MBM_WORD_W +: `MBM_WORD_W];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // port strobes
  // ----------------------------------------------------------------
  assign a_wr = !porta_chip_select_n && porta_write_not_read &&
                porta_enable;
  assign a_rd = !porta_chip_select_n && !porta_write_not_read &&
                porta_enable;
  assign b_rd = !portb_chip_select_n && portb_read_enable;
  assign c_wr = portc_write_enable;

  // either reset of a fifo empties its data path
  assign f1_clear = !fifo1_master_reset_n || !fifo1_partial_reset_n;
  assign f2_clear = !fifo2_master_reset_n || !fifo2_partial_reset_n;

  // ----------------------------------------------------------------
  // configuration taken at the end of master reset
  // ----------------------------------------------------------------
  // endian sampled on the rise of either master reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mst1_prev  <= `MBM_PREV_RST;
      mst2_prev  <= `MBM_PREV_RST;
      cfg_big    <= `MBM_BIG_RST;
      cfg_b_byte <= `MBM_BYTE_RST;
      cfg_c_byte <= `MBM_BYTE_RST;
    end else begin
      mst1_prev <= fifo1_master_reset_n;
      mst2_prev <= fifo2_master_reset_n;
      if ((fifo1_master_reset_n && !mst1_prev) ||
          (fifo2_master_reset_n && !mst2_prev)) begin
        cfg_big <= big_endian_sel;
      end
      if (fifo1_master_reset_n && !mst1_prev) begin
        cfg_b_byte <= portb_byte_size_sel;
      end
      if (fifo2_master_reset_n && !mst2_prev) begin
        cfg_c_byte <= portc_byte_size_sel;
      end
    end
  end

  // ----------------------------------------------------------------
  // a-to-b mail register and its flag
  // ----------------------------------------------------------------
  // write only while empty; a read never touches the data
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      a_to_b_mail_reg    <= {`MBM_WORD_W{1'b0}};
      a_to_b_mail_full_n <= `MBM_FLAG_RST;
    end else if (!fifo1_master_reset_n) begin
      a_to_b_mail_full_n <= `MBM_FLAG_RST;
    end else if (a_wr && porta_mail_select &&
                 a_to_b_mail_full_n) begin
      // write beats a same-edge read: flag goes low
      a_to_b_mail_full_n <= 1'b0;
      if (cfg_b_byte) begin
        a_to_b_mail_reg <= {{(`MBM_WORD_W-`MBM_BYTE_W){1'b0}},
                            porta_data_in[`MBM_BYTE_MSB:0]};
      end else begin
        a_to_b_mail_reg <= porta_data_in[`MBM_WORD_MSB:0];
      end
    end else if (b_rd && portb_mail_select) begin
      a_to_b_mail_full_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // c-to-a mail register and its flag
  // ----------------------------------------------------------------
  // port c has no chip select; the write enable alone qualifies
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      c_to_a_mail_reg    <= {`MBM_WORD_W{1'b0}};
      c_to_a_mail_full_n <= `MBM_FLAG_RST;
    end else if (!fifo2_master_reset_n) begin
      c_to_a_mail_full_n <= `MBM_FLAG_RST;
    end else if (c_wr && portc_mail_select &&
                 c_to_a_mail_full_n) begin
      c_to_a_mail_full_n <= 1'b0;
      if (cfg_c_byte) begin
        c_to_a_mail_reg <= {{(`MBM_WORD_W-`MBM_BYTE_W){1'b0}},
                            portc_data_in[`MBM_BYTE_MSB:0]};
      end else begin
        c_to_a_mail_reg <= portc_data_in;
      end
    end else if (a_rd && porta_mail_select) begin
      c_to_a_mail_full_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // fifo1: port a long words toward port b
  // ----------------------------------------------------------------
  mbm_fifo #(
    .WIDTH (`MBM_LONG_W),
    .DEPTH (`MBM_FIFO_DEPTH),
    .AW    (`MBM_FIFO_AW)
  ) u_fifo1 (
    .clk       (clk),
    .rst       (rst),
    .clear     (f1_clear),
    .in_valid  (a_wr && !porta_mail_select),
    .in_ready  (f1_in_ready),
    .in_data   (porta_data_in),
    .out_valid (f1_out_valid),
    .out_ready (f1_pop),
    .out_data  (f1_out_data)
  );

  // ----------------------------------------------------------------
  // port b unpacking of fifo1 long words
  // ----------------------------------------------------------------
  assign b_last = cfg_b_byte ? `MBM_LAST_BYTE : `MBM_LAST_WORD;
  // only the first part of a long word pops the fifo
  assign f1_pop = b_rd && !portb_mail_select &&
                  (part == 2'h0);

  // first part out, rest held, later reads walk the held word
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hold          <= {`MBM_LONG_W{1'b0}};
      part          <= 2'h0;
      portb_out_reg <= {`MBM_WORD_W{1'b0}};
    end else if (f1_clear) begin
      part <= 2'h0;
    end else if (b_rd && !portb_mail_select) begin
      if (part == 2'h0) begin
        if (f1_out_valid) begin
          hold          <= f1_out_data;
          portb_out_reg <= part_sel(f1_out_data, 2'h0,
                                    cfg_b_byte, cfg_big);
          part          <= 2'h1;
        end
      end else begin
        portb_out_reg <= part_sel(hold, part,
                                  cfg_b_byte, cfg_big);
        part          <= (part == b_last) ? 2'h0 : part + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // port c packing into fifo2
  // ----------------------------------------------------------------
  mbm_pack u_pack (
    .clk        (clk),
    .rst        (rst),
    .clear      (f2_clear),
    .byte_mode  (cfg_c_byte),
    .big        (cfg_big),
    .wr_valid   (c_wr && !portc_mail_select),
    .wr_ready   (f2_in_ready),
    .wr_data    (portc_data_in),
    .word_valid (f2_in_valid),
    .word_data  (f2_in_data)
  );

  mbm_fifo #(
    .WIDTH (`MBM_LONG_W),
    .DEPTH (`MBM_FIFO_DEPTH),
    .AW    (`MBM_FIFO_AW)
  ) u_fifo2 (
    .clk       (clk),
    .rst       (rst),
    .clear     (f2_clear),
    .in_valid  (f2_in_valid),
    .in_ready  (f2_in_ready),
    .in_data   (f2_in_data),
    .out_valid (f2_out_valid),
    .out_ready (f2_pop),
    .out_data  (f2_out_data)
  );

  // ----------------------------------------------------------------
  // port a reads of fifo2
  // ----------------------------------------------------------------
  assign f2_pop = a_rd && !porta_mail_select;

  // fifo output register loads on each accepted read
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      porta_out_reg <= {`MBM_LONG_W{1'b0}};
    end else if (f2_pop && f2_out_valid) begin
      porta_out_reg <= f2_out_data;
    end
  end

  // ----------------------------------------------------------------
  // flags and output buses
  // ----------------------------------------------------------------
  // low while a reset of that fifo is held or when full
  assign fifo1_full_or_input_ready = f1_in_ready;
  assign fifo2_full_or_input_ready = f2_in_ready;
  assign fifo1_output_ready = f1_out_valid || (part != 2'h0);
  assign fifo2_output_ready = f2_out_valid;

  // mail passes on fixed lanes, no endian swap
  assign porta_data_out = porta_mail_select ?
           {c_to_a_mail_reg, {`MBM_CA_MAIL_LSB{1'b0}}}
         : porta_out_reg;
  assign portb_data_out = portb_mail_select ?
           a_to_b_mail_reg
         : portb_out_reg;
  assign porta_data_oe  = !porta_chip_select_n && !porta_write_not_read;
  assign portb_data_oe  = !portb_chip_select_n;
endmodule // mbm_top
`default_nettype wire

// ==== verif/mbm_reader.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// port b consumer: reads fifo parts or mail, stalls when slow
// ----------------------------------------------------------------
module mbm_reader (
  input  wire logic        clk,
  input  wire logic [7:0]  want,
  input  wire logic        mail,
  input  wire logic        slow,
  input  wire logic [17:0] data,
  output var  logic        cs_n,
  output var  logic        re,
  output var  logic        msel
);
  logic [35:0] cap [0:255];
  int          n = 0;
  int          iss = 0;
  logic        pend = 1'b0;
  // bus idle until the first falling edge
  initial begin
    cs_n = 1'b1;
    re = 1'b0;
    msel = 1'b0;
  end
  // keep what the last read showed, then maybe launch another
  always @(negedge clk) begin
    if (pend) begin
      cap[n] = {18'h0, data};
      n = n + 1;
    end
    msel = mail;
    pend = iss < want && !(slow && $urandom_range(1, 0) == 1);
    cs_n = !pend;
    re = pend;
    iss = iss + int'(pend);
  end
endmodule // mbm_reader
`default_nettype wire

// ==== verif/mbm_top_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// port level checks of the mailbox and bus matching block
// ----------------------------------------------------------------
module mbm_top_properties (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        fifo1_master_reset_n,
  input wire logic        fifo2_master_reset_n,
  input wire logic        porta_chip_select_n,
  input wire logic        porta_write_not_read,
  input wire logic        porta_enable,
  input wire logic        porta_mail_select,
  input wire logic        porta_data_oe,
  input wire logic        portb_chip_select_n,
  input wire logic        portb_read_enable,
  input wire logic        portb_mail_select,
  input wire logic [17:0] portb_data_out,
  input wire logic        portc_write_enable,
  input wire logic        portc_mail_select,
  input wire logic        fifo2_output_ready,
  input wire logic        a_to_b_mail_full_n,
  input wire logic        c_to_a_mail_full_n
);
  // decoded requests of the three ports
  wire a_go = !porta_chip_select_n && porta_enable;
  wire a_mw = a_go && porta_write_not_read && porta_mail_select;
  wire a_mr = a_go && !porta_write_not_read && porta_mail_select;
  wire b_mr = !portb_chip_select_n && portb_read_enable && portb_mail_select;
  wire c_mw = portc_write_enable && portc_mail_select;
  wire c_fw = portc_write_enable && !portc_mail_select;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_ab_mail_load: assert property (
    a_mw && a_to_b_mail_full_n && fifo1_master_reset_n
    |=> !a_to_b_mail_full_n) else $error("a to b mail not flagged");
  a_ab_mail_hold: assert property (
    !a_to_b_mail_full_n && !b_mr && fifo1_master_reset_n
    |=> !a_to_b_mail_full_n) else $error("a to b flag lost");
  a_ab_mail_free: assert property (
    b_mr && !(a_mw && a_to_b_mail_full_n)
    |=> a_to_b_mail_full_n) else $error("a to b flag kept after read");
  a_ca_mail_load: assert property (
    c_mw && c_to_a_mail_full_n && fifo2_master_reset_n
    |=> !c_to_a_mail_full_n) else $error("c to a mail not flagged");
  a_ca_mail_free: assert property (
    a_mr && !(c_mw && c_to_a_mail_full_n)
    |=> c_to_a_mail_full_n) else $error("c to a flag kept after read");
  a_mail_kept: assert property (
    !a_to_b_mail_full_n && fifo1_master_reset_n && portb_mail_select ##1
    portb_mail_select |-> $stable(portb_data_out))
    else $error("full mail changed");
  a_porta_dir: assert property (
    a_go |-> porta_data_oe == !porta_write_not_read)
    else $error("port a drive enable wrong");
  a_fifo2_push: assert property (
    $rose(fifo2_output_ready) |-> $past(c_fw))
    else $error("fifo2 filled without a port c write");
endmodule // mbm_top_properties
bind mbm_top mbm_top_properties u_props (
  .clk, .rst, .fifo1_master_reset_n, .fifo2_master_reset_n,
  .porta_chip_select_n, .porta_write_not_read, .porta_enable,
  .porta_mail_select, .porta_data_oe, .portb_chip_select_n,
  .portb_read_enable, .portb_mail_select, .portb_data_out,
  .portc_write_enable, .portc_mail_select, .fifo2_output_ready,
  .a_to_b_mail_full_n, .c_to_a_mail_full_n);
`default_nettype wire

// ==== verif/mbm_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// bench: mail both ways, fill and drain fifo1, assemble into fifo2
// ----------------------------------------------------------------
module mbm_top_test;
  logic        clk = 1'b0, rst = 1'b1, big_endian_sel = 1'b1;
  logic        fifo1_master_reset_n = 1'b1, fifo2_master_reset_n = 1'b1;
  logic        fifo1_partial_reset_n = 1'b1, fifo2_partial_reset_n = 1'b1;
  logic        portb_byte_size_sel = 1'b0, portc_byte_size_sel = 1'b0;
  logic        porta_chip_select_n = 1'b1, porta_write_not_read = 1'b0;
  logic        porta_enable = 1'b0, porta_mail_select = 1'b0;
  logic        portc_write_enable = 1'b0, portc_mail_select = 1'b1;
  logic        porta_data_oe, portb_chip_select_n, portb_read_enable;
  logic        portb_mail_select, portb_data_oe, a_to_b_mail_full_n;
  logic        fifo1_full_or_input_ready, fifo2_full_or_input_ready;
  logic        fifo1_output_ready, fifo2_output_ready, c_to_a_mail_full_n;
  logic        rd_mail = 1'b0, rd_slow = 1'b0, be, byt;
  logic [35:0] porta_data_in = 36'h0, porta_data_out, v, m, w [0:8];
  logic [17:0] portc_data_in = 18'h0, portb_data_out, c;
  logic [7:0]  want = 8'h0;
  int          num_errors = 0, checked = 0, i, k, np, base;
  mbm_top DUT (
    .clk, .rst, .fifo1_master_reset_n, .fifo2_master_reset_n,
    .fifo1_partial_reset_n, .fifo2_partial_reset_n, .big_endian_sel,
    .portb_byte_size_sel, .portc_byte_size_sel, .porta_chip_select_n,
    .porta_write_not_read, .porta_enable, .porta_mail_select,
    .porta_data_in, .porta_data_out, .porta_data_oe, .portb_chip_select_n,
    .portb_read_enable, .portb_mail_select, .portb_data_out,
    .portb_data_oe, .portc_write_enable, .portc_mail_select,
    .portc_data_in, .fifo1_full_or_input_ready, .fifo2_full_or_input_ready,
    .fifo1_output_ready, .fifo2_output_ready, .a_to_b_mail_full_n,
    .c_to_a_mail_full_n);
  mbm_reader u_rd (.clk, .want, .mail(rd_mail), .slow(rd_slow),
    .data(portb_data_out), .cs_n(portb_chip_select_n),
    .re(portb_read_enable), .msel(portb_mail_select));
  // free running 10 mhz clock
  initial forever #50 clk = ~clk;
  // compare and count
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic summarize;
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // expected port b or c part p of a long word
  function automatic logic [35:0] part(input logic [35:0] x, input int p);
    int j;
    j = be ? p : np - 1 - p;
    if (byt)
      return {27'h0, x[35 - 9 * j -: 9]};
    return {18'h0, x[35 - 18 * j -: 18]};
  endfunction
  // usable mail lanes for the current size
  function automatic logic [35:0] mb(input logic [35:0] x);
    return byt ? {27'h0, x[8:0]} : {18'h0, x[17:0]};
  endfunction
  // one port a transfer, held across one rising edge
  task automatic a_op(input logic wr, ms, input logic [35:0] d);
    @(negedge clk);
    {porta_chip_select_n, porta_enable} = 2'b01;
    {porta_write_not_read, porta_mail_select, porta_data_in} = {wr, ms, d};
    @(negedge clk);
    {porta_chip_select_n, porta_enable} = 2'b10;
  endtask
  // one port c write
  task automatic c_wr(input logic ms, input logic [17:0] d);
    @(negedge clk);
    {portc_write_enable, portc_mail_select, portc_data_in} = {1'b1, ms, d};
    @(negedge clk);
    portc_write_enable = 1'b0;
  endtask
  // master reset both fifos with a new endian and size setting
  task automatic cfg;
    @(negedge clk);
    big_endian_sel = be;
    {portb_byte_size_sel, portc_byte_size_sel} = {byt, byt};
    portc_mail_select = 1'b1;
    {fifo1_master_reset_n, fifo2_master_reset_n} = 2'b00;
    repeat (2) @(negedge clk);
    {fifo1_master_reset_n, fifo2_master_reset_n} = 2'b11;
    @(negedge clk);
    check(36'(fifo2_full_or_input_ready), 36'h1);
  endtask
  // let the port b consumer take cnt more reads
  task automatic rd(input logic [7:0] cnt);
    logic [7:0] t;
    int j;
    t = want + cnt;
    want <= t;
    for (j = 0; j < 900 && u_rd.n != int'(t); j++)
      @(negedge clk);
    check(36'(u_rd.n), 36'(t));
  endtask
  // main sequence over both sizes and both byte orders
  initial begin
    void'($urandom(32'h2204));
    repeat (12) @(negedge clk);
    rst = 1'b0;
    for (i = 0; i < 4; i++) begin
      be = i[0];
      byt = i[1];
      np = byt ? 4 : 2;
      cfg();
      // fill fifo1 past its depth, then drain it with a stalling reader
      for (k = 0; k < 9; k++) begin
        w[k] = {4'($urandom), $urandom};
        a_op(1'b1, 1'b0, w[k]);
      end
      check(36'(fifo1_full_or_input_ready), 36'h0);
      rd_mail <= 1'b0;
      rd_slow <= 1'b1;
      base = u_rd.n;
      rd(8'(8 * np));
      for (k = 0; k < 8 * np; k++)
        check(u_rd.cap[base + k], part(w[k / np], k % np));
      check(36'({fifo1_output_ready, portb_data_oe}), 36'h0);
      // assemble one long word on port c, junk on unused lanes
      v = {4'($urandom), $urandom};
      for (k = 0; k < np; k++) begin
        c = {byt ? 9'($urandom) : 9'h0, 9'h0};
        c_wr(1'b0, c | 18'(part(v, k)));
        check(36'(fifo2_output_ready), 36'(k == np - 1));
      end
      a_op(1'b0, 1'b0, 36'h0);
      check(porta_data_out, v);
      // mail each way; a second write while full is dropped
      m = {4'($urandom), $urandom};
      a_op(1'b1, 1'b1, m);
      check(36'(a_to_b_mail_full_n), 36'h0);
      a_op(1'b1, 1'b1, ~m);
      rd_mail <= 1'b1;
      base = u_rd.n;
      rd(8'h2);
      check(u_rd.cap[base], mb(m));
      check(u_rd.cap[base + 1], mb(m));
      check(36'(a_to_b_mail_full_n), 36'h1);
      c = 18'($urandom);
      c_wr(1'b1, c);
      check(36'(c_to_a_mail_full_n), 36'h0);
      a_op(1'b0, 1'b1, 36'h0);
      check(36'(porta_data_out[35:18]) & mb('1), mb(36'(c)));
      check(36'(c_to_a_mail_full_n), 36'h1);
    end
    // a partial reset empties fifo1 but keeps waiting mail
    a_op(1'b1, 1'b0, v);
    a_op(1'b1, 1'b1, m);
    fifo1_partial_reset_n = 1'b0;
    @(negedge clk);
    fifo1_partial_reset_n = 1'b1;
    check(36'({fifo1_output_ready, a_to_b_mail_full_n}), 36'h0);
    summarize();
  end
  // cut a hang short
  initial begin
    #2000000;
    num_errors++;
    summarize();
  end
endmodule // mbm_top_test
`default_nettype wire
